// File: core/oes_gate.sv
// one registered clock gate: passes a source only while enabled
`timescale 1ns/1ns
module oes_gate
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic en_i,
   input  wire logic src_i,
   output logic      out_o
);
   logic out_r;
   logic out_nxt;

   // disabled output is held low, not left floating
   always_comb
   begin
      out_nxt = en_i & src_i;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         out_r <= 1'b0;
      else
         out_r <= out_nxt;
   end

   assign out_o = out_r;
endmodule // oes_gate

// File: core/oes_top.sv
// apb register holding output enables and the seventh output rate select
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
module oes_top
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        multiframe_sync_i,
   input  wire logic        frame_sync_i,
   input  wire logic        line_timing_clock_i,
   input  wire logic        composite_clock_i,
   input  wire logic        second_digital_frequency_i,
   input  wire logic [15:0] pll_div_i,
   output logic             multiframe_sync_output_o,
   output logic             frame_sync_output_o,
   output logic             line_timing_clock_output_o,
   output logic             composite_clock_output_o,
   output logic             seventh_clock_output_o,
   output logic      [7:0]  cfg_o
);
   // configuration register and its next value
   // the register is the only software visible state of the block;
   // everything else is derived from it and the source levels
   logic [7:0]  cfg_r;
   logic [7:0]  cfg_nxt;
   // registered bus answer: read data, error flag and ready strobe
   // all three are flip-flops so the bus outputs carry no decode glitches
   logic [31:0] rd_r;
   logic [31:0] rd_nxt;
   logic        err_r;
   logic        err_nxt;
   logic        rdy_r;
   logic        rdy_nxt;
   // seventh output flop and the selected source feeding it
   logic        sev_r;
   logic        sev_nxt;
   // per output vectors, index 4 down to 1 for the dedicated outputs
   // index 0 belongs to the seventh output, which has its own selector
   logic [4:0]  src;
   logic [4:0]  en;
   logic [4:0]  gated;
   oes_pkg::oes_cfg_s cfg_s;

   // bus phase and address decode helpers
   logic setup;
   logic access;
   logic hit_cfg;
   logic hit_stat;

   // register layout, low byte of the bus word:
   //    bit 7    multiframe sync output enable
   //    bit 6    frame sync output enable
   //    bit 5    line timing clock output enable
   //    bit 4    composite clock output enable
   //    bits 3:0 seventh output rate select code
   // upper 24 bits read as zero and are dropped on write
   //
   // status word, read only, bits 4:0:
   //    bit 4    multiframe sync output as driven
   //    bit 3    frame sync output as driven
   //    bit 2    line timing clock output as driven
   //    bit 1    composite clock output as driven
   //    bit 0    seventh clock output as driven
   // a write to the status word is refused with an error

   assign cfg_s    = cfg_r;
   assign setup    = psel & ~penable;
   assign access   = psel & penable & rdy_r;
   assign hit_cfg  = (paddr == oes_pkg::OES_ADDR_CFG);
   assign hit_stat = (paddr == oes_pkg::OES_ADDR_STAT);

   // bus side: answer one cycle after setup, so pready is registered
   // transfer walk, zero wait states:
   //    edge n   setup seen; read data, error and ready are prepared
   //    edge n+1 access completes with ready high; a write lands here
   // ready drops again at edge n+1 since setup is no longer seen,
   // so back to back transfers each take exactly two cycles
   // refused transfers: unmapped offset, or write to the status word;
   // a write with the low byte strobe clear is ignored without error
   always_comb
   begin
      cfg_nxt = cfg_r;
      rd_nxt  = rd_r;
      err_nxt = 1'b0;
      rdy_nxt = setup;
      if (setup)
      begin
         rd_nxt = 32'h0000_0000;
         if (!pwrite && hit_cfg)
            rd_nxt = {24'h00_0000, cfg_r};
         else if (!pwrite && hit_stat)
            rd_nxt = {27'h000_0000, gated};
         err_nxt = ~(hit_cfg | (hit_stat & ~pwrite));
      end
      // write only lands at the completing edge
      if (access && pwrite && hit_cfg && pstrb[0])
         cfg_nxt = pwdata[7:0];
   end

   // register the bus side; reset leaves all four outputs enabled
   // and no transfer pending, so the first setup may follow at once
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cfg_r <= oes_pkg::OES_CFG_RESET;
         rd_r  <= 32'h0000_0000;
         err_r <= 1'b0;
         rdy_r <= 1'b0;
      end
      else
      begin
         cfg_r <= cfg_nxt;
         rd_r  <= rd_nxt;
         err_r <= err_nxt;
         rdy_r <= rdy_nxt;
      end
   end

   // seventh output selector; upper codes come from a divided pll vector
   // codes 4 to 15 each take one bit of the divided vector, so the
   // divider outside the block decides which pll rate a code carries
   // all sixteen codes are listed, so no code is illegal
   always_comb
   begin
      unique case (cfg_s.seventh_sel)
         oes_pkg::OES_SEL_OFF:  sev_nxt = 1'b0;
         oes_pkg::OES_SEL_2K:   sev_nxt = multiframe_sync_i;
         oes_pkg::OES_SEL_8K:   sev_nxt = frame_sync_i;
         oes_pkg::OES_SEL_DIG2: sev_nxt = second_digital_frequency_i;
         4'h4:                  sev_nxt = pll_div_i[4];
         4'h5:                  sev_nxt = pll_div_i[5];
         4'h6:                  sev_nxt = pll_div_i[6];
         4'h7:                  sev_nxt = pll_div_i[7];
         4'h8:                  sev_nxt = pll_div_i[8];
         4'h9:                  sev_nxt = pll_div_i[9];
         4'ha:                  sev_nxt = pll_div_i[10];
         4'hb:                  sev_nxt = pll_div_i[11];
         4'hc:                  sev_nxt = pll_div_i[12];
         4'hd:                  sev_nxt = pll_div_i[13];
         4'he:                  sev_nxt = pll_div_i[14];
         4'hf:                  sev_nxt = pll_div_i[15];
      endcase
   end

   // seventh output flop; a code change shows one cycle later, like the
   // gated outputs, so all five outputs keep the same latency

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         sev_r <= 1'b0;
      else
         sev_r <= sev_nxt;
   end

   // dedicated outputs and their enables, one gate each
   // an enable cleared in mid cycle of a source cuts it at once; no
   // attempt is made to finish a running period, a limitation to note
   // downstream logic sees a low level while an output is disabled
   assign src = {multiframe_sync_i, frame_sync_i, line_timing_clock_i,
                 composite_clock_i, 1'b0};
   assign en  = {cfg_s.multiframe_sync_enable,
                 cfg_s.frame_sync_enable,
                 cfg_s.line_timing_clock_enable,
                 cfg_s.composite_clock_enable,
                 1'b0};

   genvar g;
   generate
      for (g = 1; g < 5; g++)
      begin : g_gate
         oes_gate u_gate
         (
            .clk_i (clk_i),
            .rst_i (rst_i),
            .en_i  (en[g]),
            .src_i (src[g]),
            .out_o (gated[g])
         );
      end
   endgenerate
   assign gated[0] = sev_r;

   // every output comes straight from a flip-flop:
   //    dedicated outputs from the gate flops
   //    seventh output from its own flop
   //    bus outputs and the register copy from the bus side flops
   assign multiframe_sync_output_o   = gated[4];
   assign frame_sync_output_o        = gated[3];
   assign line_timing_clock_output_o = gated[2];
   assign composite_clock_output_o   = gated[1];
   assign seventh_clock_output_o     = sev_r;
   assign cfg_o   = cfg_r;
   assign prdata  = rd_r;
   assign pready  = rdy_r;
   assign pslverr = err_r;
endmodule // oes_top

// File: include/oes_pkg.sv
// package: register map, field layout and reset value of the output enable block
package oes_pkg;
   // register map
   localparam logic [7:0] OES_ADDR_CFG   = 8'h00;
   localparam logic [7:0] OES_ADDR_STAT  = 8'h04;
   localparam logic [7:0] OES_CFG_RESET  = 8'hf6;
   // field positions
   localparam int OES_BIT_MFS    = 7;
   localparam int OES_BIT_FS     = 6;
   localparam int OES_BIT_LT     = 5;
   localparam int OES_BIT_CC     = 4;
   localparam int OES_SEL_LSB    = 0;
   localparam int OES_SEL_W      = 4;
   // seventh output selector codes
   typedef enum logic [3:0] {
      OES_SEL_OFF   = 4'b0000,
      OES_SEL_2K    = 4'b0001,
      OES_SEL_8K    = 4'b0010,
      OES_SEL_DIG2  = 4'b0011
   } oes_sel_e;
   // gate bundle towards the clock outputs
   typedef struct packed {
      logic       multiframe_sync_enable;
      logic       frame_sync_enable;
      logic       line_timing_clock_enable;
      logic       composite_clock_enable;
      logic [3:0] seventh_sel;
   } oes_cfg_s;
endpackage

// File: test/oes_top_checker.sv
// port assertions for the output enable and rate select register
`timescale 1ns/1ns
module oes_top_checker
(
   input logic        clk_i, rst_i, psel, penable, pwrite, pready,
   input logic [7:0]  paddr, cfg_o,
   input logic [31:0] pwdata,
   input logic [3:0]  pstrb,
   input logic        multiframe_sync_i, frame_sync_i, line_timing_clock_i,
   input logic        composite_clock_i, second_digital_frequency_i,
   input logic        multiframe_sync_output_o, frame_sync_output_o,
   input logic        line_timing_clock_output_o, composite_clock_output_o,
   input logic        seventh_clock_output_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // each dedicated output is last cycle's source and enable; $past guard skips reset
   AST_MFS: assert property (!$past(rst_i) |-> multiframe_sync_output_o ==
      $past(multiframe_sync_i & cfg_o[7])) else $error("multiframe gate wrong");
   AST_FS: assert property (!$past(rst_i) |-> frame_sync_output_o ==
      $past(frame_sync_i & cfg_o[6])) else $error("frame gate wrong");
   AST_LT: assert property (!$past(rst_i) |-> line_timing_clock_output_o ==
      $past(line_timing_clock_i & cfg_o[5])) else $error("line timing gate wrong");
   AST_CC: assert property (!$past(rst_i) |-> composite_clock_output_o ==
      $past(composite_clock_i & cfg_o[4])) else $error("composite gate wrong");
   AST_OFF: assert property (!$past(rst_i) && $past(cfg_o[3:0]) == 4'h0 |->
      !seventh_clock_output_o) else $error("seventh not off");
   AST_DIG: assert property (!$past(rst_i) && $past(cfg_o[3:0]) == 4'h3 |->
      seventh_clock_output_o == $past(second_digital_frequency_i)) else $error("code 3 wrong");
   AST_RST: assert property ($fell(rst_i) |-> cfg_o == 8'hf6) else $error("bad reset");
   AST_WR: assert property (psel && penable && pready && pwrite && paddr == 8'h00
      && pstrb[0] |=> cfg_o == $past(pwdata[7:0])) else $error("write lost");
endmodule // oes_top_checker
bind oes_top oes_top_checker u_chk (.*);

// File: test/oes_top_tb.sv
// self-checking bench for the output enable and rate select register
`timescale 1ns/1ns
module oes_top_tb;
   logic        clk_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
   logic [7:0]  paddr = 0, cfg_o, mdl = 8'hf6;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [3:0]  pstrb = 4'hf;
   logic [4:0]  src = 0, outs;
   logic [15:0] pll = 0;
   int          err_total = 0, n_tests = 0;
   oes_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .multiframe_sync_i(src[4]), .frame_sync_i(src[3]),
      .line_timing_clock_i(src[2]), .composite_clock_i(src[1]),
      .second_digital_frequency_i(src[0]), .pll_div_i(pll), .cfg_o(cfg_o),
      .multiframe_sync_output_o(outs[4]), .frame_sync_output_o(outs[3]),
      .line_timing_clock_output_o(outs[2]), .composite_clock_output_o(outs[1]),
      .seventh_clock_output_o(outs[0]));
   // free-running clock
   initial forever #5 clk_i = ~clk_i;
   task chk(input string nm, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_total++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // one apb transfer; request held until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1;
      do @(posedge clk_i); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clk_i);
   endtask
   // model of the seventh output mux
   function logic e7(input int c);
      case (c)
         0: return 0;
         1: return src[4];
         2: return src[3];
         3: return src[0];
         default: return pll[c];
      endcase
   endfunction
   // sources held two edges so the one-cycle late outputs settle
   task run(input int n);
      repeat (n)
      begin
         src <= 5'($urandom);
         pll <= 16'($urandom);
         @(posedge clk_i);
         @(posedge clk_i);
         #1 chk("outs", outs, {src[4:1] & mdl[7:4], e7(mdl[3:0])});
      end
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // watchdog: the sequence needs well under 2000 cycles
   initial
   begin
      #200000;
      err_total++;
      finish_test;
   end
   initial
   begin
      void'($urandom(92667));
      repeat (12) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      apb(0, 8'h00, 0);
      chk("reset", rd, 32'hf6);
      // every selector code; codes 1 and 2 keep all enables on
      for (int c = 0; c < 16; c++)
      begin
         mdl = {(c inside {1, 2}) ? 4'hf : 4'($urandom), 4'(c)};
         apb(1, 8'h00, {24'($urandom), mdl});
         run(4);
         apb(0, 8'h00, 0);
         chk("read", rd, {24'h0, mdl});
         chk("rd_err", er, 0);
         apb(0, 8'h04, 0);
         chk("stat", rd, {27'h0, src[4:1] & mdl[7:4], e7(mdl[3:0])});
      end
      $display("selector test done");
      // refused writes and a write with the low byte strobe clear leave the register alone
      apb(1, 8'h10, 0);
      chk("unmapped", er, 1);
      apb(1, 8'h04, 0);
      chk("status", er, 1);
      pstrb <= 4'h0;
      apb(1, 8'h00, 0);
      chk("cfg", cfg_o, mdl);
      $display("refusal test done");
      // reset in mid run restores the default and clears the outputs
      pstrb <= 4'hf;
      rst_i <= 1;
      repeat (2) @(posedge clk_i);
      rst_i <= 0;
      #1 chk("rst_outs", outs, 0);
      @(posedge clk_i);
      mdl = 8'hf6;
      apb(0, 8'h00, 0);
      chk("rerst", rd, 32'hf6);
      run(2);
      $display("reset test done");
      finish_test;
   end
endmodule // oes_top_tb
